// ==== core/dma_chan_ctrl.sv ====
// channel request, delay, stall detection and interrupt control, AHB-Lite slave
// assumes: one clock, synchronous reset, inputs synchronous to clk_sys_i
// Function
// - i/o mode requests only after device request
// - memory mode requests when wait count zero
// - bits 15:13 are stall interval or delay
// - i/o mode stall flag after interval exceeded
// - stall code zero disables stall detection
// - stall codes select 960 to 4194240 clocks
// - memory mode waits delay before next request
// - delay code zero requests continuously
// - delay codes 1..3 give 16,32,64 clocks
// - error enable gates error and stall interrupt
// - chain enable gates chain end interrupt
// - transfer enable gates transfer end interrupt
// - mode, code and enables reset to zero
// - channel reset clears logic, flags, requests
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`include "dma_chan_ctrl_map.svh"
module dma_chan_ctrl
  import dma_chan_ctrl_pkg::*;
#(
  parameter int GAP_WIDTH = 23,
  parameter int STALL_SCALE = `STALL_UNIT
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // i/o device request and internal bus arbiter
  input wire logic io_req_i,
  input wire logic bus_grant_i,
  input wire logic bus_done_i,
  output logic bus_req_o,
  // transfer engine events
  input wire logic error_end_i,
  input wire logic chain_end_i,
  input wire logic xfer_end_i,
  // interrupt
  output logic irq_o
);
  logic [31:0] control_ff; // channel control register
  logic [3:0] status_ff; // sticky status flags
  logic [3:0] mask_ff; // event mask register
  logic [31:0] hrdata_ff; // read data
  logic wr_pend_ff; // write data phase pending
  logic [11:0] wr_addr_ff; // latched write address
  own_state_e own_ff; // ownership state
  logic [9:0] wait_ff; // wait counter
  logic [9:0] nxt_wait; // delay for current code
  logic [GAP_WIDTH-1:0] gap_cnt; // clocks without ownership
  logic [GAP_WIDTH-1:0] stall_lim; // stall limit for current code
  logic stall_hit; // stall detected this cycle
  logic chan_rst; // channel reset bit
  logic io_mode; // request source select
  logic active; // transfer active
  code_t code; // shared delay / stall code
  logic [3:0] ev_set; // events this cycle
  logic [3:0] w1c; // write-one-to-clear bits
  logic [3:0] irq_gate; // per-flag interrupt enables
  logic addr_ok; // valid address phase
  logic seen_release_ff; // ownership given up since i/o mode began

  assign chan_rst = control_ff[`BIT_CHAN_RESET];
  assign io_mode = control_ff[`BIT_REQ_SOURCE];
  assign active = control_ff[`BIT_ACTIVE];
  assign code = control_ff[`FLD_CODE_HI:`FLD_CODE_LO];
  assign addr_ok = hsel_i && hready_i && htrans_i[1];

  // bus slave: zero wait states, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_ff;

  // capture write address phase
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end else begin
      wr_pend_ff <= addr_ok && hwrite_i;
      wr_addr_ff <= haddr_i;
    end
  end

  // read data registered in the address phase; unmapped reads zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_i) begin
      case (haddr_i)
        `OFS_CONTROL: hrdata_ff <= control_ff;
        `OFS_STATUS: hrdata_ff <= {28'h000_0000, status_ff};
        `OFS_IRQ_MASK: hrdata_ff <= {28'h000_0000, mask_ff};
        `OFS_EVENT: hrdata_ff <= {20'h0_0000, wait_ff, own_ff};
        default: hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // control register; active bit cleared by channel reset, error or transfer end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      control_ff <= `CONTROL_RESET;
    end else if (wr_pend_ff && wr_addr_ff == `OFS_CONTROL) begin
      control_ff <= hwdata_i;
      if (hwdata_i[`BIT_CHAN_RESET]) begin
        control_ff[`BIT_ACTIVE] <= 1'b0;
      end
    end else if (chan_rst || error_end_i || xfer_end_i) begin
      control_ff[`BIT_ACTIVE] <= 1'b0;
    end
  end

  // mask register, same layout as status
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mask_ff <= 4'h0;
    end else if (wr_pend_ff && wr_addr_ff == `OFS_IRQ_MASK) begin
      mask_ff <= hwdata_i[3:0];
    end
  end

  // delay per code; top codes provisional, pending confirmation
  always_comb begin
    case (code)
      3'h1: nxt_wait = 10'(`DELAY_CODE1);
      3'h2: nxt_wait = 10'(`DELAY_CODE2);
      3'h3: nxt_wait = 10'(`DELAY_CODE3);
      3'h4: nxt_wait = 10'(`DELAY_CODE4);
      3'h5: nxt_wait = 10'(`DELAY_CODE5);
      3'h6: nxt_wait = 10'(`DELAY_CODE6);
      3'h7: nxt_wait = 10'(`DELAY_CODE7);
      default: nxt_wait = 10'h000;
    endcase
  end

  // stall limit = (4^(code+1) - 1) * unit
  always_comb begin
    case (code)
      3'h1: stall_lim = GAP_WIDTH'(`STALL_MULT1 * STALL_SCALE);
      3'h2: stall_lim = GAP_WIDTH'(`STALL_MULT2 * STALL_SCALE);
      3'h3: stall_lim = GAP_WIDTH'(`STALL_MULT3 * STALL_SCALE);
      3'h4: stall_lim = GAP_WIDTH'(`STALL_MULT4 * STALL_SCALE);
      3'h5: stall_lim = GAP_WIDTH'(`STALL_MULT5 * STALL_SCALE);
      3'h6: stall_lim = GAP_WIDTH'(`STALL_MULT6 * STALL_SCALE);
      3'h7: stall_lim = GAP_WIDTH'(`STALL_MULT7 * STALL_SCALE);
      default: stall_lim = '0;
    endcase
  end

  // ownership sequencing; channel reset drops any pending request
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || chan_rst || !active) begin
      own_ff <= OWN_IDLE;
      wait_ff <= 10'h000;
    end else begin
      unique case (own_ff)
        OWN_IDLE: begin
          if (io_mode ? io_req_i : (wait_ff == 10'h000)) begin
            own_ff <= OWN_REQUEST;
          end else if (wait_ff != 10'h000) begin
            wait_ff <= wait_ff - 10'h001;
          end
        end
        OWN_REQUEST: begin
          if (bus_grant_i) begin
            own_ff <= OWN_HELD;
          end
        end
        OWN_HELD: begin
          if (bus_done_i) begin
            // release after each bus operation
            own_ff <= (io_mode || nxt_wait == 10'h000) ? OWN_IDLE : OWN_WAIT;
            wait_ff <= io_mode ? 10'h000 : nxt_wait;
          end
        end
        OWN_WAIT: begin
          own_ff <= OWN_IDLE; // counter runs down in idle
          wait_ff <= wait_ff - 10'h001;
        end
      endcase
    end
  end

  // request while waiting for grant; io needs device request
  assign bus_req_o = (own_ff == OWN_REQUEST);

  // stall timing starts at the first release, not at activation
  // a channel that never owned the bus cannot be stalled
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || chan_rst || !active || !io_mode) begin
      seen_release_ff <= 1'b0;
    end else if (own_ff == OWN_HELD && bus_done_i) begin
      seen_release_ff <= 1'b1;
    end
  end

  // count clocks without ownership in i/o mode only
  dma_gap_counter #(
    .WIDTH(GAP_WIDTH)
  ) u_gap (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clear_i(chan_rst || !io_mode || own_ff == OWN_HELD || !active),
    .run_i(own_ff != OWN_HELD && seen_release_ff),
    .count_o(gap_cnt)
  );

  // exceeding, not reaching, the interval flags a stall
  assign stall_hit = io_mode && code != 3'h0 && gap_cnt > stall_lim;

  assign ev_set = {stall_hit, xfer_end_i, chain_end_i, error_end_i};
  assign w1c = (wr_pend_ff && wr_addr_ff == `OFS_STATUS) ? hwdata_i[3:0] : 4'h0;

  // sticky status: set wins over write-one clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || chan_rst) begin
      status_ff <= 4'h0;
    end else begin
      status_ff <= (status_ff & ~w1c) | ev_set;
    end
  end

  // enables from control, then mask register
  assign irq_gate[`ST_ERROR_END] = control_ff[`BIT_ERR_IRQ_EN];
  assign irq_gate[`ST_STALLED] = control_ff[`BIT_ERR_IRQ_EN];
  assign irq_gate[`ST_CHAIN_END] = control_ff[`BIT_CHAIN_IRQ_EN];
  assign irq_gate[`ST_XFER_END] = control_ff[`BIT_XFER_IRQ_EN];
  assign irq_o = |(status_ff & irq_gate & ~mask_ff);

  // assertions
  sequence s_release;
    own_ff == OWN_HELD && bus_done_i && !io_mode && code == 3'h1;
  endsequence

  sequence s_delay_hold;
    active && !chan_rst && !io_mode && code == 3'h1;
  endsequence
  sequence s_hold8;
    s_delay_hold[*8];
  endsequence

  a_reset_clears: assert property (@(posedge clk_sys_i)
    $fell(rst_i) |-> control_ff[16:10] == 7'h00)
    else $error("control fields not zero after reset");
  a_chan_rst_flags: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    chan_rst |=> status_ff == 4'h0 && !bus_req_o)
    else $error("channel reset left flags or request");
  a_io_needs_req: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    own_ff == OWN_IDLE && io_mode && !io_req_i && !chan_rst |=> !bus_req_o)
    else $error("io request without device request");
  a_delay_16: assert property (@(posedge clk_sys_i) disable iff (rst_i || chan_rst)
    s_release ##1 s_hold8 ##1 s_hold8 |-> !bus_req_o)
    else $error("request before delay elapsed");
  a_stall_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    code == 3'h0 && !w1c[3] |=> !$rose(status_ff[`ST_STALLED]))
    else $error("stall flagged with code zero");
  a_stall_set: assert property (@(posedge clk_sys_i) disable iff (rst_i || chan_rst)
    stall_hit |=> status_ff[`ST_STALLED])
    else $error("stall not flagged");
  a_err_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    status_ff[`ST_ERROR_END] && control_ff[12] && !mask_ff[0] |-> irq_o)
    else $error("error interrupt missing");
  a_no_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    control_ff[12:10] == 3'h0 |-> !irq_o)
    else $error("interrupt with all enables off");
  a_xfer_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    status_ff[`ST_XFER_END] && control_ff[10] && !mask_ff[2] |-> irq_o)
    else $error("transfer end interrupt missing");

  // delay code 1: the request returns once the sixteen quiet clocks are over
  a_delay_end: assert property (@(posedge clk_sys_i) disable iff (rst_i || chan_rst)
    s_release ##1 s_hold8 ##1 s_hold8 ##1 s_delay_hold[*2] |-> bus_req_o)
    else $error("request missing after delay");
  a_mem_request: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    own_ff == OWN_IDLE && active && !chan_rst && !io_mode && wait_ff == 10'h000 |=> bus_req_o)
    else $error("memory mode request missing at zero wait");
  a_io_request: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    own_ff == OWN_IDLE && active && !chan_rst && io_mode && io_req_i |=> bus_req_o)
    else $error("io request not followed by ownership request");
  // interrupt gating per enable bit
  a_chain_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    status_ff[`ST_CHAIN_END] && control_ff[`BIT_CHAIN_IRQ_EN] && !mask_ff[`ST_CHAIN_END] |-> irq_o)
    else $error("chain end interrupt missing");
  a_stall_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    status_ff[`ST_STALLED] && control_ff[`BIT_ERR_IRQ_EN] && !mask_ff[`ST_STALLED] |-> irq_o)
    else $error("stall interrupt missing");
  a_err_gate_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !control_ff[`BIT_ERR_IRQ_EN] && !status_ff[`ST_CHAIN_END] && !status_ff[`ST_XFER_END]
      |-> !irq_o)
    else $error("error or stall interrupt while error enable off");
endmodule : dma_chan_ctrl

// ==== core/dma_chan_ctrl_map.svh ====
// register offsets, field positions, reset values and timing counts
// assumes: included by the channel control module and the testbench
`ifndef DMA_CHAN_CTRL_MAP_SVH
`define DMA_CHAN_CTRL_MAP_SVH
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_MASK 12'h008
`define OFS_EVENT 12'h00C
`define BIT_CHAN_RESET 24
`define BIT_REQ_SOURCE 16
`define FLD_CODE_HI 15
`define FLD_CODE_LO 13
`define BIT_ERR_IRQ_EN 12
`define BIT_CHAIN_IRQ_EN 11
`define BIT_XFER_IRQ_EN 10
`define BIT_ACTIVE 8
`define CONTROL_RESET 32'h0100_0000
`define ST_ERROR_END 0
`define ST_CHAIN_END 1
`define ST_XFER_END 2
`define ST_STALLED 3
`define DELAY_CODE1 16
`define DELAY_CODE2 32
`define DELAY_CODE3 64
`define DELAY_CODE4 128
`define DELAY_CODE5 256
`define DELAY_CODE6 512
`define DELAY_CODE7 512
`define STALL_UNIT 64
`define STALL_MULT1 15
`define STALL_MULT2 63
`define STALL_MULT3 255
`define STALL_MULT4 1023
`define STALL_MULT5 4095
`define STALL_MULT6 16383
`define STALL_MULT7 65535
`endif

// ==== core/dma_chan_ctrl_pkg.sv ====
// types shared by the channel control logic
// assumes: compiled before the design modules
package dma_chan_ctrl_pkg;
  typedef enum logic [1:0] {
    OWN_IDLE,
    OWN_REQUEST,
    OWN_HELD,
    OWN_WAIT
  } own_state_e;
  typedef logic [2:0] code_t;
endpackage : dma_chan_ctrl_pkg

// ==== core/dma_gap_counter.sv ====
// saturating counter of clocks spent without bus ownership
// assumes: clear is held while the channel owns the bus or is outside i/o mode
module dma_gap_counter #(
  parameter int WIDTH = 23
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire logic run_i,
  // count
  output logic [WIDTH-1:0] count_o
);
  logic [WIDTH-1:0] count_ff; // saturating count

  // saturate so a long stall never wraps to a small value
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || clear_i) begin
      count_ff <= '0;
    end else if (run_i && count_ff != {WIDTH{1'b1}}) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  assign count_o = count_ff;
endmodule : dma_gap_counter

// ==== verification/dma_arbiter_model.sv ====
// partner model: internal bus arbiter serving one channel
// assumes: one clock, the channel requests ownership as a level
module dma_arbiter_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // channel side
  input wire logic bus_req_i,
  output logic bus_grant_o,
  output logic bus_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] own_ff; // cycles left in the current bus operation
  // grant a request, own the bus briefly, then pulse the release
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_grant_o <= 1'b0;
      bus_done_o <= 1'b0;
      own_ff <= 2'h0;
    end else begin
      bus_done_o <= 1'b0;
      if (bus_grant_o) begin
        own_ff <= own_ff - 2'h1;
        if (own_ff == 2'h0) begin // operation over, give the bus back
          bus_grant_o <= 1'b0;
          bus_done_o <= 1'b1;
        end
      end else if (bus_req_i && !bus_done_o) begin // one idle cycle after release
        bus_grant_o <= 1'b1;
        own_ff <= 2'h2;
      end
    end
  end
endmodule : dma_arbiter_model

// ==== verification/dma_channel_request_stall_irq_ctrl_bench.sv ====
// testbench: register access, request timing, stall flag and interrupts
// assumes: design built with STALL_SCALE 1, so stall code 1 means 15 clocks
`include "dma_chan_ctrl_map.svh"
module dma_channel_request_stall_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, rst_i, hsel, hwrite, io_req, grant, done, bus_req, irq, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [2:0] ev; // error, chain and transfer end pulses
  int errors, samples_checked, n, lim;
  dma_chan_ctrl #(.STALL_SCALE(1)) i_dma_chan_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .io_req_i(io_req), .bus_grant_i(grant), .bus_done_i(done),
    .bus_req_o(bus_req), .error_end_i(ev[0]), .chain_end_i(ev[1]), .xfer_end_i(ev[2]),
    .irq_o(irq));
  dma_arbiter_model i_dma_arbiter_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .bus_req_i(bus_req), .bus_grant_o(grant), .bus_done_o(done));
  // free running clock, 40 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // single place where the run ends
  task automatic tally_and_finish();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // signals that the bounded wait can watch, by index
  localparam int W_READY = 0;
  localparam int W_DONE = 1;
  localparam int W_REQ = 2;
  localparam int W_IRQ = 3;
  function automatic logic probe(input int which);
    case (which)
      W_READY: return hreadyout;
      W_DONE: return done;
      W_REQ: return bus_req;
      default: return irq;
    endcase
  endfunction : probe
  // bounded wait, sampled once per edge; a hang ends the run
  task automatic wait_for(input int which, input logic v, input int bound, output int cnt);
    cnt = 0;
    while (probe(which) !== v) begin
      @(posedge clk_sys_i);
      cnt++;
      if (cnt > bound) begin
        chk("wait timeout", 32'h1, 32'h0);
        tally_and_finish();
      end
    end
  endtask : wait_for
  // one ahb-lite single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk_sys_i);
    wait_for(W_READY, 1'b1, 20, k);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_i);
    wait_for(W_READY, 1'b1, 20, k);
    rd = hrdata;
  endtask : xfer
  // one-cycle event or device request pulse
  task automatic pulse(input logic [2:0] e, input logic req);
    ev <= e;
    io_req <= req;
    @(posedge clk_sys_i);
    ev <= 3'h0;
    io_req <= 1'b0;
    @(posedge clk_sys_i);
  endtask : pulse
  initial begin
    {rst_i, hsel, hwrite, io_req, haddr, htrans, hwdata, ev} = '0;
    rst_i = 1'b1;
    errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    xfer(0, `OFS_CONTROL, 0);
    chk("control reset", 32'h0100_0000, rd);
    chk("ready", 32'h1, hreadyout);
    chk("okay response", 32'h0, hresp);
    xfer(0, `OFS_STATUS, 0);
    chk("status reset", 32'h0, rd);
    xfer(0, 12'h010, 0);
    chk("unmapped read", 32'h0, rd);
    // memory mode: gap from release to next request per delay code
    for (int c = 0; c < 4; c++) begin
      xfer(1, `OFS_CONTROL, 32'h100 | (32'(c) << 13));
      wait_for(W_DONE, 1'b1, 300, n);
      @(posedge clk_sys_i);
      wait_for(W_DONE, 1'b1, 300, n); // second release runs under the new code
      @(posedge clk_sys_i);
      wait_for(W_REQ, 1'b1, 300, n);
      lim = (c == 0) ? 0 : (8 << c);
      chk("request gap", 32'h1, 32'(n >= lim && n <= lim + 4));
    end
    xfer(1, `OFS_CONTROL, 32'h0);
    // io mode, stall detection off, error interrupt on
    xfer(1, `OFS_CONTROL, 32'h0001_1100);
    repeat (20) @(posedge clk_sys_i);
    chk("io idle request", 32'h0, bus_req);
    pulse(3'h0, 1'b1);
    wait_for(W_DONE, 1'b1, 20, n);
    repeat (60) @(posedge clk_sys_i);
    chk("stall off irq", 32'h0, irq);
    // stall code 1: restart idle so the count begins at the next release
    xfer(1, `OFS_CONTROL, 32'h0);
    xfer(1, `OFS_CONTROL, 32'h0001_3100);
    pulse(3'h0, 1'b1);
    wait_for(W_DONE, 1'b1, 20, n);
    wait_for(W_IRQ, 1'b1, 40, n);
    chk("stall delay", 32'h1, 32'(n >= 14 && n <= 22));
    // channel idle, error enable kept on, so the flag alone drives the line
    xfer(1, `OFS_CONTROL, 32'h0000_1000);
    xfer(0, `OFS_STATUS, 0);
    chk("stall flag", 32'h8, rd);
    chk("stall irq held", 32'h1, irq);
    xfer(1, `OFS_STATUS, 32'h8);
    @(posedge clk_sys_i);
    chk("stall cleared irq", 32'h0, irq);
    xfer(1, `OFS_CONTROL, 32'h0);
    // each event: no interrupt while disabled, then enabled, masked, cleared
    for (int i = 0; i < 3; i++) begin
      pulse(3'(1 << i), 1'b0);
      xfer(0, `OFS_STATUS, 0);
      chk("event status", 32'(1 << i), rd);
      chk("irq disabled", 32'h0, irq);
      xfer(1, `OFS_CONTROL, 32'h1 << (12 - i));
      @(posedge clk_sys_i);
      chk("irq enabled", 32'h1, irq);
      xfer(1, `OFS_IRQ_MASK, 32'(1 << i));
      @(posedge clk_sys_i);
      chk("irq masked", 32'h0, irq);
      xfer(1, `OFS_IRQ_MASK, 32'h0);
      xfer(1, `OFS_STATUS, 32'(1 << i));
      @(posedge clk_sys_i);
      chk("irq cleared", 32'h0, irq);
    end
    // channel reset in mid-run drops the request and clears status
    xfer(1, `OFS_CONTROL, 32'h0000_0900);
    pulse(3'h2, 1'b0);
    chk("chain irq", 32'h1, irq);
    xfer(1, `OFS_CONTROL, 32'h0100_0900);
    repeat (2) @(posedge clk_sys_i);
    chk("reset request", 32'h0, bus_req);
    chk("reset irq", 32'h0, irq);
    xfer(0, `OFS_STATUS, 0);
    chk("reset status", 32'h0, rd);
    xfer(0, `OFS_CONTROL, 0);
    chk("reset active", 32'h0, rd & 32'h100);
    // second reset in mid-run brings back the reset control value
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    xfer(0, `OFS_CONTROL, 0);
    chk("control after reset", 32'h0100_0000, rd);
    tally_and_finish();
  end
endmodule : dma_channel_request_stall_irq_ctrl_bench
